/* File: core/vhc_defs.svh */
// Register offsets, field positions, reset values and mode and rate codes of the host control block.
`ifndef VHC_DEFS_SVH
`define VHC_DEFS_SVH
`define VHC_OFF_START 7'h05
`define VHC_OFF_STOP 7'h06
`define VHC_OFF_BSTART 7'h07
`define VHC_OFF_BSTOP 7'h08
`define VHC_OFF_BACK 7'h09
`define VHC_OFF_IEN 7'h0C
`define VHC_OFF_ISTAT 7'h0D
`define VHC_OFF_ICLR 7'h0E
`define VHC_OFF_IRDCLR 7'h0F
`define VHC_OFF_THR 7'h10
`define VHC_OFF_MODE 7'h11
`define VHC_OFF_FMT 7'h12
`define VHC_OFF_ENC 7'h13
`define VHC_RST_IEN 8'h00
`define VHC_RST_ISTAT 7'h40
`define VHC_RST_THR 6'h04
`define VHC_RST_MODE 5'h00
`define VHC_RST_FMT 4'h5
`define VHC_RST_ENC 8'h0C
`define VHC_BIT_EOD 0
`define VHC_BIT_RDY 1
`define VHC_BIT_OVF 2
`define VHC_BIT_DERR 3
`define VHC_BIT_SYNC 4
`define VHC_BIT_VBV 5
`define VHC_BIT_SRDY 6
`define VHC_NSRC 7
`define VHC_MODE_LIVE_ENC 4'h0
`define VHC_MODE_LIVE_PASS 4'h1
`define VHC_MODE_SINGLE 4'h3
`define VHC_MODE_WR_FRAME 4'h4
`define VHC_MODE_LAST 4'h9
`define VHC_FMT_PAL 2'h2
`define VHC_POL_CBR 2'h0
`define VHC_RATE_NTSC 4'h4
`define VHC_RATE_PAL 4'h3
`define VHC_GROUP_SHIFT 2
`endif

/* File: core/vhc_host_ctrl.sv */
// Host command, interrupt and configuration registers of the video encoder.
// How it works
// - Stop write ends transfer; in live modes it drops current frame.
// - Bus command writes issue START, STOP, ACK.
// - Enable register bits 0-6, resets zero.
// - End of data set after last read.
// - FIFO ready set when count exceeds threshold.
// - Overflow flagged and FIFO writes then blocked.
// - Write-frame byte count mismatch sets data error.
// - Out-of-sync bit follows decoder sync loss.
// - Underflow only in live MPEG1 constant rate.
// - Serial ready set when link goes idle; reset 0x40.
// - Status sets regardless of enables.
// - Interrupt pin combinational from enable and status.
// - Clear register ones clear status bits.
// - Cleared ready masked until threshold read.
// - Read-clear register clears only FIFO ready.
// - Ready drives FIFO-ready pin when master enabled.
// - Threshold counts groups of four bus words.
// - Mode field selects ten modes plus format.
// - Format register selects size and standard.
// - Single-frame rate code from picture format.
// - Encoder options reset to 0x0C.
// - Live start write begins at next odd field; modes 2-9 at once.
`timescale 1ns/1ps
`include "vhc_defs.svh"
module vhc_host_ctrl #(
    parameter int CNT_W = 12
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_bus_width_sel,
    input wire logic i_master_enable_pin,
    input wire logic [CNT_W-1:0] i_fifo_bytes,
    input wire logic i_fifo_full,
    input wire logic i_fifo_push,
    input wire logic i_fifo_pop,
    input wire logic i_stream_done,
    input wire logic i_host_byte_wr,
    input wire logic i_frame_end,
    input wire logic [CNT_W+7:0] i_expected_bytes,
    input wire logic i_decoder_sync_lost,
    input wire logic i_vbv_underflow,
    input wire logic i_serial_busy,
    input wire logic i_odd_field_start,
    input wire logic i_frame_start,
    output logic o_fifo_wr_block,
    output logic o_fifo_rdy,
    output logic o_irq_n,
    output vhc_pkg::vhc_ser_cmd_s o_ser_cmd,
    output logic o_encoding,
    output logic o_frame_discard,
    output logic [3:0] o_frame_rate_code,
    output logic [4:0] o_work_mode,
    output logic [3:0] o_picture_format,
    output vhc_pkg::vhc_enc_s o_enc_opts,
    output logic [5:0] o_fifo_threshold
);
    logic rst1_q;
    logic rst_n_q;
    logic [7:0] ien_q;
    logic [5:0] thr_q;
    logic [4:0] mode_q;
    logic [3:0] fmt_q;
    logic [7:0] enc_q;
    vhc_pkg::vhc_xfer_e xfer_q;
    vhc_pkg::vhc_ser_cmd_s ser_q;
    logic discard_q;
    logic [7:0] rdata_q;
    logic rdy_mask_q;
    logic [CNT_W-1:0] pops_q;
    logic ovf_q;
    logic busy_q;
    logic [CNT_W+7:0] wr_bytes_q;
    logic [`VHC_NSRC-1:0] set_v;
    logic [`VHC_NSRC-1:0] clr_v;
    logic [`VHC_NSRC-1:0] status;
    logic [CNT_W-1:0] thr_bytes;
    logic wr_stop;
    logic wr_start;
    logic rd_rdclr;
    logic wr_clr;
    logic live;
    logic above;
    logic wr_bstart;
    logic wr_bstop;
    logic wr_back;
    logic [CNT_W-1:0] thr_elems;
    logic [CNT_W+7:0] wr_bytes_d;
    logic [7:0] rdata_d;

    // Reset is released through two stages so every register leaves it in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst1_q <= 1'b1;
            rst_n_q <= rst1_q;
        end
    end

    assign wr_start = i_reg_wr && i_reg_addr == `VHC_OFF_START;
    assign wr_stop = i_reg_wr && i_reg_addr == `VHC_OFF_STOP;
    assign wr_clr = i_reg_wr && i_reg_addr == `VHC_OFF_ICLR;
    assign rd_rdclr = i_reg_rd && i_reg_addr == `VHC_OFF_IRDCLR;
    // Each command write is a strobe; the data written with it is ignored.
    assign wr_bstart = i_reg_wr && i_reg_addr == `VHC_OFF_BSTART;
    assign wr_bstop = i_reg_wr && i_reg_addr == `VHC_OFF_BSTOP;
    assign wr_back = i_reg_wr && i_reg_addr == `VHC_OFF_BACK;
    assign live = mode_q[3:0] == `VHC_MODE_LIVE_ENC || mode_q[3:0] == `VHC_MODE_LIVE_PASS;

    // Threshold is in groups of four bus words; width 8, 16 or 32 bits.
    always_comb begin
        case (i_bus_width_sel)
            2'h0: thr_bytes = CNT_W'({thr_q, 2'b00});
            2'h1: thr_bytes = CNT_W'({thr_q, 3'b000});
            default: thr_bytes = CNT_W'({thr_q, 4'b0000});
        endcase
    end
    assign above = i_fifo_bytes > thr_bytes;
    // Elements the host must read before a cleared ready bit may return.
    assign thr_elems = CNT_W'({thr_q, 2'b00});

    // Reserved bits are dropped on write so they always read back as zero.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ien_q <= `VHC_RST_IEN;
        end else if (i_reg_wr && i_reg_addr == `VHC_OFF_IEN) begin
            ien_q <= {1'b0, i_reg_wdata[6:0]};
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            thr_q <= `VHC_RST_THR;
        end else if (i_reg_wr && i_reg_addr == `VHC_OFF_THR) begin
            thr_q <= i_reg_wdata[5:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= `VHC_RST_MODE;
        end else if (i_reg_wr && i_reg_addr == `VHC_OFF_MODE) begin
            mode_q <= i_reg_wdata[4:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fmt_q <= `VHC_RST_FMT;
        end else if (i_reg_wr && i_reg_addr == `VHC_OFF_FMT) begin
            fmt_q <= i_reg_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            enc_q <= `VHC_RST_ENC;
        end else if (i_reg_wr && i_reg_addr == `VHC_OFF_ENC) begin
            enc_q <= i_reg_wdata;
        end
    end

    // Bus condition strobes last one cycle after the command write.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ser_q <= '0;
        end else begin
            ser_q.start <= wr_bstart;
            ser_q.stop <= wr_bstop;
            ser_q.ack <= wr_back;
        end
    end

    // Transfer sequencing; a live start waits for the next odd field.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            xfer_q <= vhc_pkg::VHC_XFER_IDLE;
            discard_q <= 1'b0;
        end else begin
            case (xfer_q)
                vhc_pkg::VHC_XFER_IDLE: begin
                    if (wr_start && live) begin
                        xfer_q <= vhc_pkg::VHC_XFER_DRAIN;
                    end else if (wr_start && mode_q[3:0] <= `VHC_MODE_LAST) begin
                        xfer_q <= vhc_pkg::VHC_XFER_RUN;
                    end
                end
                vhc_pkg::VHC_XFER_DRAIN: begin
                    if (wr_stop) begin
                        xfer_q <= vhc_pkg::VHC_XFER_IDLE;
                    end else if (i_odd_field_start) begin
                        xfer_q <= vhc_pkg::VHC_XFER_RUN;
                    end
                end
                vhc_pkg::VHC_XFER_RUN: begin
                    if (wr_stop) begin
                        xfer_q <= vhc_pkg::VHC_XFER_IDLE;
                    end
                end
                default: xfer_q <= vhc_pkg::VHC_XFER_IDLE;
            endcase
            // The frame in progress at stop is dropped; earlier ones already went out.
            if (wr_stop && live && xfer_q == vhc_pkg::VHC_XFER_RUN) begin
                discard_q <= 1'b1;
            end else if (i_frame_start) begin
                discard_q <= 1'b0;
            end
        end
    end

    // FIFO ready stays masked after a clear until one threshold of elements is read.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdy_mask_q <= 1'b0;
            pops_q <= '0;
        end else if (clr_v[`VHC_BIT_RDY]) begin
            rdy_mask_q <= 1'b1;
            pops_q <= '0;
        end else if (rdy_mask_q && i_fifo_pop) begin
            pops_q <= pops_q + 1'b1;
            if (CNT_W'(pops_q + 1'b1) >= thr_elems) begin
                rdy_mask_q <= 1'b0;
            end
        end
    end

    // Only a start write lifts the block, so the host must restart after an overrun.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ovf_q <= 1'b0;
        end else if (i_fifo_push && i_fifo_full) begin
            ovf_q <= 1'b1;
        end else if (wr_start) begin
            ovf_q <= 1'b0;
        end
    end

    // Serial ready is flagged on the falling edge of busy, one cycle late.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= i_serial_busy;
        end
    end

    // A byte written in the frame-end cycle still counts toward the frame.
    assign wr_bytes_d = wr_bytes_q + (CNT_W+8)'(i_host_byte_wr);

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_bytes_q <= '0;
        end else if (wr_start || i_frame_end) begin
            wr_bytes_q <= '0;
        end else begin
            wr_bytes_q <= wr_bytes_d;
        end
    end

    // Each source sets its own sticky bit; enables are applied only at the pin.
    always_comb begin
        set_v = '0;
        set_v[`VHC_BIT_EOD] = i_stream_done;
        // Ready is a level, so a clear must win here or the bit would come straight back.
        set_v[`VHC_BIT_RDY] = above && !rdy_mask_q && !clr_v[`VHC_BIT_RDY];
        set_v[`VHC_BIT_OVF] = i_fifo_push && i_fifo_full;
        set_v[`VHC_BIT_DERR] = mode_q[3:0] == `VHC_MODE_WR_FRAME && i_frame_end
            && wr_bytes_d != i_expected_bytes;
        set_v[`VHC_BIT_SYNC] = i_decoder_sync_lost;
        set_v[`VHC_BIT_VBV] = i_vbv_underflow && mode_q[3:0] == `VHC_MODE_LIVE_ENC
            && !mode_q[4] && enc_q[1:0] == `VHC_POL_CBR;
        set_v[`VHC_BIT_SRDY] = busy_q && !i_serial_busy;
    end

    always_comb begin
        clr_v = wr_clr ? i_reg_wdata[`VHC_NSRC-1:0] : '0;
        clr_v[`VHC_BIT_RDY] = clr_v[`VHC_BIT_RDY] | rd_rdclr;
        // Sync loss is a live level, so it drops when the decoder relocks.
        clr_v[`VHC_BIT_SYNC] = clr_v[`VHC_BIT_SYNC] | !i_decoder_sync_lost;
    end

    vhc_irq_status #(
        .NSRC(`VHC_NSRC)
    ) vhc_irq_status_inst (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n_q),
        .i_set(set_v),
        .i_clr(clr_v),
        .i_enable(ien_q[`VHC_NSRC-1:0]),
        .o_status(status),
        .o_irq_n(o_irq_n)
    );

    // Read data registered one cycle after the read strobe.
    always_comb begin
        case (i_reg_addr)
            `VHC_OFF_IEN: rdata_d = ien_q;
            `VHC_OFF_ISTAT: rdata_d = {1'b0, status};
            `VHC_OFF_IRDCLR: rdata_d = {1'b0, status};
            `VHC_OFF_THR: rdata_d = {2'b00, thr_q};
            `VHC_OFF_MODE: rdata_d = {3'b000, mode_q};
            `VHC_OFF_FMT: rdata_d = {4'h0, fmt_q};
            `VHC_OFF_ENC: rdata_d = enc_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_fifo_rdy = status[`VHC_BIT_RDY] && i_master_enable_pin;
    assign o_fifo_wr_block = ovf_q;
    assign o_ser_cmd = ser_q;
    assign o_encoding = xfer_q == vhc_pkg::VHC_XFER_RUN;
    assign o_frame_discard = discard_q;
    // Rate code follows the picture standard in single-frame mode; reserved reads as NTSC.
    always_comb begin
        case (fmt_q[3:2])
            `VHC_FMT_PAL: o_frame_rate_code = `VHC_RATE_PAL;
            default: o_frame_rate_code = `VHC_RATE_NTSC;
        endcase
    end
    assign o_work_mode = mode_q;
    assign o_picture_format = fmt_q;
    assign o_enc_opts = enc_q;
    assign o_fifo_threshold = thr_q;
endmodule

/* File: core/vhc_irq_status.sv */
// Sticky interrupt status bits with set-over-clear and the active-low interrupt pin.
`timescale 1ns/1ps
`include "vhc_defs.svh"
module vhc_irq_status #(
    parameter int NSRC = `VHC_NSRC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [NSRC-1:0] i_set,
    input wire logic [NSRC-1:0] i_clr,
    input wire logic [NSRC-1:0] i_enable,
    output logic [NSRC-1:0] o_status,
    output logic o_irq_n
);
    localparam logic [NSRC-1:0] RST_VAL = NSRC'(`VHC_RST_ISTAT);
    logic [NSRC-1:0] status_q;
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_bit
            // Set wins over clear so an event in the clear cycle is kept.
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    status_q[g] <= RST_VAL[g];
                end else if (i_set[g]) begin
                    status_q[g] <= 1'b1;
                end else if (i_clr[g]) begin
                    status_q[g] <= 1'b0;
                end
            end
        end
    endgenerate
    assign o_status = status_q;
    // Combinational so enable writes take effect at once.
    assign o_irq_n = ~|(status_q & i_enable);
endmodule

/* File: core/vhc_pkg.sv */
// Types shared by the host control block.
package vhc_pkg;
    typedef enum logic [1:0] {
        VHC_XFER_IDLE = 2'b00,
        VHC_XFER_RUN = 2'b01,
        VHC_XFER_DRAIN = 2'b10
    } vhc_xfer_e;
    typedef struct packed {
        logic start;
        logic stop;
        logic ack;
    } vhc_ser_cmd_s;
    typedef struct packed {
        logic time_stamp;
        logic scene_change;
        logic inv_telecine;
        logic closed_gop;
        logic b_start;
        logic half_pixel;
        logic [1:0] rate_policy;
    } vhc_enc_s;
endpackage

/* File: dv/vhc_host_ctrl_bench.sv */
// Self-checking testbench of the host control block.
`timescale 1ns/1ps
module vhc_host_ctrl_bench;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [6:0] i_reg_addr = 7'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [1:0] i_bus_width_sel = 2'h0;
    logic i_master_enable_pin = 1'b0;
    logic [11:0] i_fifo_bytes = 12'h000;
    logic i_fifo_full = 1'b0;
    logic i_decoder_sync_lost = 1'b0;
    logic [19:0] i_expected_bytes = 20'h00003;
    logic [7:0] ev = 8'h00;
    logic i_stream_done, i_fifo_push, i_fifo_pop, i_host_byte_wr, i_frame_end;
    logic i_vbv_underflow, i_odd_field_start, i_frame_start, i_serial_busy;
    logic [7:0] o_reg_rdata;
    logic o_fifo_wr_block, o_fifo_rdy, o_irq_n, o_encoding, o_frame_discard;
    vhc_pkg::vhc_ser_cmd_s o_ser_cmd;
    logic [3:0] o_frame_rate_code, o_picture_format;
    logic [4:0] o_work_mode;
    vhc_pkg::vhc_enc_s o_enc_opts;
    logic [5:0] o_fifo_threshold;
    int bad_count = 0;
    int checked = 0;
    localparam logic [6:0] RA [9] = '{7'h0C, 7'h0D, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13, 7'h0A, 7'h0E};
    localparam logic [7:0] RV [9] = '{8'h00, 8'h40, 8'h40, 8'h04, 8'h00, 8'h05, 8'h0C, 8'h00, 8'h00};
    assign {i_frame_start, i_odd_field_start, i_vbv_underflow, i_frame_end} = ev[7:4];
    assign {i_host_byte_wr, i_fifo_pop, i_fifo_push, i_stream_done} = ev[3:0];
    always #5 i_sys_clk = ~i_sys_clk;
    vhc_host_ctrl #(.CNT_W(12)) vhc_host_ctrl_inst (.*);
    vhc_serial_model vhc_serial_model_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_cmd(o_ser_cmd), .o_busy(i_serial_busy));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_reg_rdata, exp);
    endtask
    task automatic pulse(input int b);
        @(posedge i_sys_clk);
        ev[b] <= 1'b1;
        @(posedge i_sys_clk);
        ev <= 8'h00;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        for (int k = 0; k < 9; k++) rd(RA[k], RV[k]);
        chk(o_irq_n, 1'b1);
        wr(7'h0C, 8'hFF);
        @(negedge i_sys_clk);
        chk(o_irq_n, 1'b0);
        rd(7'h0C, 8'h7F);
        wr(7'h0E, 8'hFF);
        @(negedge i_sys_clk);
        chk(o_irq_n, 1'b1);
        rd(7'h0D, 8'h00);
        wr(7'h0C, 8'h00);
        $display("test reset and enables done");
        for (int k = 0; k < 3; k++) begin
            wr(7'h07 + 7'(k), 8'h00);
            @(negedge i_sys_clk);
            chk(8'(o_ser_cmd), 8'(3'b100 >> k));
        end
        repeat (2) @(posedge i_sys_clk);
        for (int n = 0; n < 50 && i_serial_busy !== 1'b0; n++) @(posedge i_sys_clk);
        if (i_serial_busy !== 1'b0) begin
            bad_count++;
            $display("BAD %0t serial link stuck busy", $time);
            stop_test();
        end
        repeat (3) @(posedge i_sys_clk);
        rd(7'h0D, 8'h40);
        wr(7'h0E, 8'h40);
        $display("test serial commands done");
        @(posedge i_sys_clk) i_fifo_full <= 1'b1;
        pulse(1);
        pulse(0);
        @(posedge i_sys_clk) i_decoder_sync_lost <= 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk(o_fifo_wr_block, 1'b1);
        chk(o_irq_n, 1'b1);
        rd(7'h0D, 8'h15);
        wr(7'h0C, 8'h10);
        @(negedge i_sys_clk);
        chk(o_irq_n, 1'b0);
        @(posedge i_sys_clk) i_decoder_sync_lost <= 1'b0;
        repeat (2) @(negedge i_sys_clk);
        chk(o_irq_n, 1'b1);
        @(posedge i_sys_clk) i_fifo_full <= 1'b0;
        wr(7'h0E, 8'h05);
        wr(7'h0C, 8'h00);
        rd(7'h0D, 8'h00);
        pulse(5);
        rd(7'h0D, 8'h20);
        wr(7'h0E, 8'h20);
        wr(7'h11, 8'h04);
        pulse(5);
        pulse(3);
        pulse(3);
        pulse(4);
        rd(7'h0D, 8'h08);
        wr(7'h0E, 8'h08);
        $display("test status events done");
        wr(7'h11, 8'h00);
        wr(7'h10, 8'h02);
        repeat (8) pulse(2);
        @(posedge i_sys_clk) i_fifo_bytes <= 12'h008;
        i_master_enable_pin <= 1'b1;
        rd(7'h0D, 8'h00);
        @(posedge i_sys_clk) i_fifo_bytes <= 12'h009;
        repeat (2) @(negedge i_sys_clk);
        chk(o_fifo_rdy, 1'b1);
        rd(7'h0F, 8'h02);
        rd(7'h0D, 8'h00);
        repeat (7) pulse(2);
        rd(7'h0D, 8'h00);
        pulse(2);
        rd(7'h0D, 8'h02);
        @(posedge i_sys_clk) i_master_enable_pin <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_fifo_rdy, 1'b0);
        wr(7'h0E, 8'h02);
        @(posedge i_sys_clk) i_bus_width_sel <= 2'h2;
        i_fifo_bytes <= 12'h011;
        repeat (8) pulse(2);
        rd(7'h0D, 8'h00);
        @(posedge i_sys_clk) i_bus_width_sel <= 2'h1;
        rd(7'h0D, 8'h02);
        wr(7'h0E, 8'h02);
        $display("test fifo ready done");
        wr(7'h05, 8'h00);
        repeat (3) @(negedge i_sys_clk);
        chk(o_encoding, 1'b0);
        pulse(6);
        @(negedge i_sys_clk);
        chk(o_encoding, 1'b1);
        wr(7'h06, 8'h00);
        @(negedge i_sys_clk);
        chk(o_encoding, 1'b0);
        chk(o_frame_discard, 1'b1);
        pulse(7);
        @(negedge i_sys_clk);
        chk(o_frame_discard, 1'b0);
        $display("test start and stop done");
        wr(7'h12, 8'h09);
        @(negedge i_sys_clk);
        chk(8'(o_frame_rate_code), 8'h03);
        rd(7'h12, 8'h09);
        wr(7'h11, 8'h19);
        rd(7'h11, 8'h19);
        chk(8'(o_work_mode), 8'h19);
        wr(7'h13, 8'hFF);
        rd(7'h13, 8'hFF);
        $display("test configuration done");
        stop_test();
    end
endmodule

/* File: dv/vhc_host_ctrl_monitor.sv */
// Concurrent checks on the ports of the host control block.
`timescale 1ns/1ps
module vhc_host_ctrl_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_master_enable_pin,
    input wire logic i_fifo_push,
    input wire logic i_fifo_full,
    input wire logic o_fifo_wr_block,
    input wire logic o_fifo_rdy,
    input wire vhc_pkg::vhc_ser_cmd_s o_ser_cmd,
    input wire logic o_encoding,
    input wire logic [3:0] o_frame_rate_code,
    input wire logic [3:0] o_picture_format,
    input wire vhc_pkg::vhc_enc_s o_enc_opts,
    input wire logic [5:0] o_fifo_threshold
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr(logic [6:0] a);
        i_reg_wr && i_reg_addr == a;
    endsequence
    // An overrun wins over a start write in the same cycle, yet that cycle is left out here.
    sequence s_overrun;
        i_fifo_push && i_fifo_full && !(i_reg_wr && i_reg_addr == 7'h05);
    endsequence
    AST_BUS_START: assert property (s_wr(7'h07) |=> o_ser_cmd.start)
        else $error("start condition not issued");
    AST_BUS_STOP: assert property (s_wr(7'h08) |=> o_ser_cmd.stop)
        else $error("stop condition not issued");
    AST_BUS_ACK: assert property (s_wr(7'h09) |=> o_ser_cmd.ack)
        else $error("acknowledge not issued");
    AST_CMD_CAUSE: assert property (o_ser_cmd != 3'b000 |-> $past(i_reg_wr))
        else $error("serial command without a write");
    AST_STOP_IDLE: assert property (s_wr(7'h06) |=> !o_encoding)
        else $error("transfer still running after stop");
    AST_OVF_BLOCK: assert property (s_overrun |=> o_fifo_wr_block)
        else $error("fifo writes not blocked after overflow");
    AST_THR_WRITE: assert property (s_wr(7'h10) |=> o_fifo_threshold == $past(i_reg_wdata[5:0]))
        else $error("threshold not stored");
    AST_ENC_WRITE: assert property (s_wr(7'h13) |=> o_enc_opts == $past(i_reg_wdata))
        else $error("encoder options not stored");
    AST_FMT_WRITE: assert property (s_wr(7'h12) |=> o_picture_format == $past(i_reg_wdata[3:0]))
        else $error("picture format not stored");
    AST_RATE_CODE: assert property (o_frame_rate_code == ((o_picture_format[3:2] == 2'h2) ? 4'h3 : 4'h4))
        else $error("frame rate code wrong for format");
    AST_RDY_PIN: assert property (o_fifo_rdy |-> i_master_enable_pin)
        else $error("fifo ready pin without master enable");
endmodule
bind vhc_host_ctrl vhc_host_ctrl_monitor vhc_host_ctrl_monitor_inst (.*);

/* File: dv/vhc_serial_model.sv */
// Behavioural two-wire link partner that stays busy for a while after each command.
`timescale 1ns/1ps
module vhc_serial_model #(
    parameter int BUSY_CYCLES = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire vhc_pkg::vhc_ser_cmd_s i_cmd,
    output logic o_busy
);
    int cnt_q;
    // Every command restarts the busy time, so the ready flag only returns after the last one.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 0;
        end else if (i_cmd != 3'b000) begin
            cnt_q <= BUSY_CYCLES;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign o_busy = (cnt_q != 0);
endmodule
